// *** rtl/indexed_address_alu.sv ***
// Summary of operation
// [RQ1] Constant-offset indirect: pointer plus offset, fetch word there as address.
// [RQ2] Accumulator indexed: signed A, B or D added to X, Y, U or S.
// [RQ3] Accumulator indexed indirect: fetch word at that sum as address.
// [RQ4] Auto-increment: old pointer is address, then pointer grows by one or two.
// [RQ5] Auto-increment indirect: fetch at old pointer, add two; by-one is illegal.
// [RQ6] Auto-decrement: pointer drops by one or two, new value is address.
// [RQ7] Auto-decrement indirect: drop by two, fetch word at new pointer.
// [RQ8] Short branch: sign-extended byte added to program counter.
// [RQ9] Long branch: 16-bit displacement added to program counter.
// [RQ10] Second accumulator zero-extended and added into first index, flags unchanged.
// [RQ11] Add with carry adds byte plus carry; plain add adds byte only.
// [RQ12] 8-bit add sets half-carry exactly on carry out of bit 3.
// [RQ13] 8-bit add sets N, Z, V and C from the result.
// [RQ14] 16-bit add: word into D, H kept, N, Z, V from result.
// [RQ15] 16-bit add carry is carry out of the high byte.
// [RQ16] AND into accumulator: N, Z set, V cleared, H and C kept.
// [RQ17] Condition AND: flags ANDed with the immediate byte.
// [RQ18] Shift left: C gets old bit 7, V gets bit 7 xor bit 6.
// [RQ19] Shift left moves bits up and puts zero in bit 0.
// [RQ20] Memory words are read high byte first, low byte next.
`include "ixalu_consts.svh"

module indexed_address_alu
    import ixalu_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Operation request
    input wire logic op_valid_in,
    input wire op_t op_in,
    // Register file load
    input wire logic load_valid_in,
    input wire regs_t regs_load_in,
    // Byte reads from system memory
    output logic mem_rd_out,
    output logic [15:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic [7:0] mem_data_in,
    // Results and status
    output regs_t regs_out,
    output logic [15:0] ea_out,
    output logic busy_out,
    output logic done_out,
    output logic illegal_out
);

    state_t state, next_state;
    regs_t regs, next_regs;
    op_t op_q, next_op;
    logic [7:0] hi_byte, next_hi;
    logic [15:0] rd_addr, next_rd_addr;
    logic [15:0] ea, next_ea;
    logic done, next_done, illegal, next_illegal;

    // ********************************
    // Helpers
    // ********************************
    function automatic logic [15:0] ptr_get(regs_t r, ptr_sel_t p);
        unique case (p)
            PTR_X: ptr_get = r.x;
            PTR_Y: ptr_get = r.y;
            PTR_U: ptr_get = r.u;
            PTR_S: ptr_get = r.s;
            PTR_PC: ptr_get = r.pc;
            default: ptr_get = `REG16_RESET;
        endcase
    endfunction : ptr_get

    function automatic regs_t ptr_put(regs_t r, ptr_sel_t p,
                                      logic [15:0] v);
        ptr_put = r;
        unique case (p)
            PTR_X: ptr_put.x = v;
            PTR_Y: ptr_put.y = v;
            PTR_U: ptr_put.u = v;
            PTR_S: ptr_put.s = v;
            PTR_PC: ptr_put.pc = v;
            default: ptr_put = r;
        endcase
    endfunction : ptr_put

    // ********************************
    // Sequencing and datapath
    // ********************************
    always_comb begin
        logic [15:0] base;
        logic [15:0] ofs;
        logic [15:0] step;
        logic [15:0] addr;
        logic [7:0] acc;
        logic [7:0] res8;
        logic [8:0] sum9;
        logic [4:0] nib;
        logic [16:0] sum17;
        logic [15:0] word;
        logic cin;
        logic bad;
        base = ptr_get(regs, op_in.ptr);
        ofs = `REG16_RESET;
        step = op_in.step_two ? `STEP_TWO : `STEP_ONE;
        addr = `REG16_RESET;
        acc = op_q.acc_second ? regs.b : regs.a;
        res8 = 8'h00;
        sum9 = 9'h000;
        nib = 5'h00;
        sum17 = 17'h00000;
        word = {hi_byte, mem_data_in};
        cin = 1'b0;
        bad = 1'b0;
        next_state = state;
        next_regs = regs;
        next_op = op_q;
        next_hi = hi_byte;
        next_rd_addr = rd_addr;
        next_ea = ea;
        next_done = 1'b0;
        next_illegal = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (op_valid_in) begin
                    next_op = op_in;
                    unique case (op_in.opcode)
                        OP_EA: begin
                            unique case (op_in.ofs)
                                OFS_A: ofs = {{8{regs.a[7]}}, regs.a}; // [RQ2]
                                OFS_B: ofs = {{8{regs.b[7]}}, regs.b}; // [RQ2]
                                OFS_D: ofs = {regs.a, regs.b}; // [RQ2]
                                default: bad = (op_in.mode == EA_ACC);
                            endcase
                            unique case (op_in.mode)
                                EA_CONST: addr = base + op_in.imm; // [RQ1]
                                EA_ACC: addr = base + ofs; // [RQ2] [RQ3]
                                EA_INC: begin
                                    addr = base; // [RQ4] [RQ5]
                                    next_regs = ptr_put(regs, op_in.ptr,
                                                        base + step);
                                end
                                EA_DEC: begin
                                    addr = base - step; // [RQ6] [RQ7]
                                    next_regs = ptr_put(regs, op_in.ptr,
                                                        addr);
                                end
                            endcase
                            // Program counter only takes constant offsets
                            if (op_in.ptr == PTR_PC &&
                                op_in.mode != EA_CONST)
                                bad = 1'b1;
                            if (op_in.indirect && !op_in.step_two &&
                                (op_in.mode == EA_INC ||
                                 op_in.mode == EA_DEC))
                                bad = 1'b1; // [RQ5] [RQ7]
                            if (bad) begin
                                next_regs = regs;
                                next_illegal = 1'b1;
                            end else if (op_in.indirect) begin
                                next_rd_addr = addr; // [RQ1] [RQ3]
                                next_state = ST_RD_HI;
                            end else begin
                                next_ea = addr;
                                next_done = 1'b1;
                            end
                        end
                        OP_BRANCH: begin
                            addr = op_in.long_rel ? op_in.imm // [RQ9]
                                 : {{8{op_in.imm[7]}}, op_in.imm[7:0]}; // [RQ8]
                            next_regs.pc = regs.pc + addr;
                            next_ea = regs.pc + addr;
                            next_done = 1'b1;
                        end
                        OP_ABX: begin
                            next_regs.x = regs.x + {8'h00, regs.b}; // [RQ10]
                            next_done = 1'b1;
                        end
                        OP_ANDCC: begin
                            next_regs.cc = regs.cc & op_in.imm[7:0]; // [RQ17]
                            next_done = 1'b1;
                        end
                        OP_ASL: begin
                            acc = op_in.acc_second ? regs.b : regs.a;
                            res8 = {acc[6:0], 1'b0}; // [RQ19]
                            if (op_in.acc_second)
                                next_regs.b = res8;
                            else
                                next_regs.a = res8;
                            next_regs.cc[`CC_C] = acc[7]; // [RQ18]
                            next_regs.cc[`CC_V] = acc[7] ^ acc[6]; // [RQ18]
                            next_regs.cc[`CC_N] = res8[7];
                            next_regs.cc[`CC_Z] = (res8 == 8'h00);
                            // Half-carry is undefined; it is left alone
                            next_done = 1'b1;
                        end
                        OP_ADD_DOUBLE_ACC: begin
                            next_rd_addr = op_in.imm;
                            next_state = ST_RD_HI;
                        end
                        default: begin
                            // Byte operands: imm carries the operand address
                            next_rd_addr = op_in.imm;
                            next_state = ST_RD_LO;
                        end
                    endcase
                end else if (load_valid_in) begin
                    next_regs = regs_load_in;
                end
            end
            ST_RD_HI: begin
                if (mem_ack_in) begin
                    next_hi = mem_data_in; // [RQ20]
                    next_rd_addr = rd_addr + `STEP_ONE;
                    next_state = ST_RD_LO;
                end
            end
            ST_RD_LO: begin
                if (mem_ack_in) begin
                    next_state = ST_IDLE;
                    next_done = 1'b1;
                    unique case (op_q.opcode)
                        OP_EA: next_ea = word; // [RQ20] [RQ1] [RQ3]
                        OP_ADD_DOUBLE_ACC: begin
                            sum17 = {1'b0, regs.a, regs.b} + {1'b0, word};
                            {next_regs.a, next_regs.b} = sum17[15:0]; // [RQ14]
                            next_regs.cc[`CC_N] = sum17[15];
                            next_regs.cc[`CC_Z] = (sum17[15:0] == 16'h0000);
                            next_regs.cc[`CC_V] = (regs.a[7] == word[15]) &&
                                                  (sum17[15] != regs.a[7]);
                            next_regs.cc[`CC_C] = sum17[16]; // [RQ15]
                        end
                        OP_AND: begin
                            res8 = acc & mem_data_in; // [RQ16]
                            if (op_q.acc_second)
                                next_regs.b = res8;
                            else
                                next_regs.a = res8;
                            next_regs.cc[`CC_N] = res8[7];
                            next_regs.cc[`CC_Z] = (res8 == 8'h00);
                            next_regs.cc[`CC_V] = 1'b0;
                        end
                        default: begin
                            cin = (op_q.opcode == OP_ADC) &
                                  regs.cc[`CC_C]; // [RQ11]
                            sum9 = {1'b0, acc} + {1'b0, mem_data_in} +
                                   {8'h00, cin};
                            nib = {1'b0, acc[3:0]} + {1'b0, mem_data_in[3:0]}
                                + {4'h0, cin};
                            res8 = sum9[7:0];
                            if (op_q.acc_second)
                                next_regs.b = res8;
                            else
                                next_regs.a = res8;
                            next_regs.cc[`CC_H] = nib[4]; // [RQ12]
                            next_regs.cc[`CC_N] = res8[7]; // [RQ13]
                            next_regs.cc[`CC_Z] = (res8 == 8'h00);
                            next_regs.cc[`CC_V] = (acc[7] == mem_data_in[7])
                                               && (res8[7] != acc[7]);
                            next_regs.cc[`CC_C] = sum9[8];
                        end
                    endcase
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // ********************************
    // State registers
    // ********************************
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_IDLE;
            op_q <= '0;
            hi_byte <= `REG8_RESET;
            rd_addr <= `REG16_RESET;
        end else begin
            state <= next_state;
            op_q <= next_op;
            hi_byte <= next_hi;
            rd_addr <= next_rd_addr;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            regs <= '{`REG8_RESET, `REG8_RESET, `REG16_RESET, `REG16_RESET,
                      `REG16_RESET, `REG16_RESET, `REG16_RESET, `CC_RESET};
        end else begin
            regs <= next_regs;
        end
    end

    // Outputs are flopped so the core sees them settled
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ea <= `REG16_RESET;
            done <= 1'b0;
            illegal <= 1'b0;
            mem_rd_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            ea <= next_ea;
            done <= next_done;
            illegal <= next_illegal;
            mem_rd_out <= (next_state != ST_IDLE);
            busy_out <= (next_state != ST_IDLE);
        end
    end

    assign mem_addr_out = rd_addr;
    assign regs_out = regs;
    assign ea_out = ea;
    assign done_out = done;
    assign illegal_out = illegal;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_start(opcode_t o);
        state == ST_IDLE && op_valid_in && op_in.opcode == o;
    endsequence

    sequence s_word_fetch;
        state == ST_RD_HI && mem_ack_in ##2 state == ST_RD_LO && mem_ack_in;
    endsequence

    property p_abx;
        s_start(OP_ABX) |=> regs.x == $past(regs.x) + {8'h00, $past(regs.b)}
                            && regs.cc == $past(regs.cc);
    endproperty
    a_abx: assert property (p_abx) else $error("index add wrong"); // [RQ10]

    property p_short_branch;
        s_start(OP_BRANCH) ##0 !op_in.long_rel |=> done_out &&
            regs.pc == $past(regs.pc) + {{8{$past(op_in.imm[7])}},
                                          $past(op_in.imm[7:0])};
    endproperty
    a_short_branch: assert property (p_short_branch) // [RQ8]
        else $error("short branch target wrong");

    property p_long_branch;
        s_start(OP_BRANCH) ##0 op_in.long_rel |=>
            regs.pc == $past(regs.pc) + $past(op_in.imm);
    endproperty
    a_long_branch: assert property (p_long_branch) // [RQ9]
        else $error("long branch target wrong");

    property p_inc;
        s_start(OP_EA) ##0 (op_in.mode == EA_INC && !op_in.indirect &&
        op_in.ptr == PTR_X) |=> done_out && ea_out == $past(regs.x) &&
            regs.x == $past(regs.x) + ($past(op_in.step_two) ? 16'h0002
                                                             : 16'h0001);
    endproperty
    a_inc: assert property (p_inc) else $error("auto-increment wrong"); // [RQ4]

    property p_dec;
        s_start(OP_EA) ##0 (op_in.mode == EA_DEC && !op_in.indirect &&
        op_in.ptr == PTR_Y) |=> ea_out == regs.y && regs.y ==
            $past(regs.y) - ($past(op_in.step_two) ? 16'h0002 : 16'h0001);
    endproperty
    a_dec: assert property (p_dec) else $error("auto-decrement wrong"); // [RQ6]

    property p_inc_ind_one;
        s_start(OP_EA) ##0 (op_in.mode == EA_INC && op_in.indirect &&
        !op_in.step_two) |=> illegal_out && !mem_rd_out &&
            regs == $past(regs);
    endproperty
    a_inc_ind_one: assert property (p_inc_ind_one) // [RQ5]
        else $error("illegal indirect form accepted");

    property p_andcc;
        s_start(OP_ANDCC) |=>
            regs.cc == ($past(regs.cc) & $past(op_in.imm[7:0]));
    endproperty
    a_andcc: assert property (p_andcc) else $error("flag AND wrong"); // [RQ17]

    property p_asl;
        s_start(OP_ASL) ##0 !op_in.acc_second |=>
            regs.a == {$past(regs.a[6:0]), 1'b0} &&
            regs.cc[`CC_C] == $past(regs.a[7]) &&
            regs.cc[`CC_V] == ($past(regs.a[7]) ^ $past(regs.a[6]));
    endproperty
    a_asl: assert property (p_asl) else $error("shift left wrong"); // [RQ18]

    property p_word_order;
        s_word_fetch ##0 op_q.opcode == OP_EA |=>
            ea_out == {$past(mem_data_in, 3), $past(mem_data_in)} && done_out;
    endproperty
    a_word_order: assert property (p_word_order) // [RQ20]
        else $error("pointer byte order wrong");

    property p_half_carry;
        state == ST_RD_LO && mem_ack_in && op_q.opcode == OP_ADD &&
        !op_q.acc_second |=> regs.cc[`CC_H] ==
            (({1'b0, $past(regs.a[3:0])} + {1'b0, $past(mem_data_in[3:0])})
             > 5'h0F);
    endproperty
    a_half_carry: assert property (p_half_carry) // [RQ12]
        else $error("half-carry wrong");

endmodule : indexed_address_alu

// *** rtl/ixalu_consts.svh ***
`ifndef IXALU_CONSTS_SVH
`define IXALU_CONSTS_SVH

// ********************************
// Condition code bit positions
// ********************************
`define CC_C 0
`define CC_V 1
`define CC_Z 2
`define CC_N 3
`define CC_H 5

// ********************************
// Reset values and steps
// ********************************
`define REG8_RESET 8'h00
`define REG16_RESET 16'h0000
`define CC_RESET 8'h50
`define STEP_ONE 16'h0001
`define STEP_TWO 16'h0002

`endif

// *** rtl/ixalu_pkg.sv ***
package ixalu_pkg;

    typedef enum logic [3:0] {
        OP_EA, OP_BRANCH, OP_ABX, OP_ADC, OP_ADD, OP_ADD_DOUBLE_ACC, OP_AND,
        OP_ANDCC, OP_ASL
    } opcode_t;

    typedef enum logic [1:0] {EA_CONST, EA_ACC, EA_INC, EA_DEC} ea_mode_t;

    typedef enum logic [2:0] {PTR_X, PTR_Y, PTR_U, PTR_S, PTR_PC} ptr_sel_t;

    typedef enum logic [1:0] {OFS_A, OFS_B, OFS_D} ofs_sel_t;

    typedef enum logic [1:0] {ST_IDLE, ST_RD_HI, ST_RD_LO} state_t;

    typedef struct packed {
        opcode_t opcode;
        ea_mode_t mode;
        logic indirect;
        logic step_two;
        ptr_sel_t ptr;
        ofs_sel_t ofs;
        logic long_rel;
        logic acc_second;
        logic [15:0] imm;
    } op_t;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] u;
        logic [15:0] s;
        logic [15:0] pc;
        logic [7:0] cc;
    } regs_t;

endpackage : ixalu_pkg

// *** verif/far_memory.sv ***
module far_memory (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Read request from the block, read delay from the testbench
    input wire logic mem_rd_in,
    input wire logic [15:0] mem_addr_in,
    input wire logic [1:0] delay_in,
    // Answer
    output logic mem_ack_out = 1'b0,
    output logic [7:0] mem_data_out = 8'hA5
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] wait_cnt;

    function automatic logic [7:0] byte_at(input logic [15:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3C;
    endfunction : byte_at

    // ********************************
    // Slow or prompt byte reads
    // ********************************
    // Data toggles outside the ack so a late capture cannot pass by luck
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_ack_out <= 1'b0;
            mem_data_out <= 8'hA5;
            wait_cnt <= 2'h0;
        end else begin
            mem_ack_out <= 1'b0;
            mem_data_out <= ~mem_data_out;
            if (mem_rd_in && !mem_ack_out) begin
                if (wait_cnt >= delay_in) begin
                    mem_ack_out <= 1'b1;
                    mem_data_out <= byte_at(mem_addr_in);
                    wait_cnt <= 2'h0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
        end
    end
endmodule : far_memory

// *** verif/testbench.sv ***
`include "ixalu_consts.svh"

module testbench import ixalu_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic op_valid_in = 1'b0;
    op_t op_in = '0;
    logic load_valid_in = 1'b0;
    regs_t regs_load_in = '0;
    logic mem_rd_out, mem_ack_in, busy_out, done_out, illegal_out;
    logic [15:0] mem_addr_out, ea_out, exp_ea;
    logic [7:0] mem_data_in;
    logic [1:0] mem_delay = 2'h0;
    regs_t regs_out, exp_regs;
    logic exp_bad;
    int miscompares = 0;
    int n_tests = 0;
    integer seed = 32'h62f3;

    always #5 mclk_in = ~mclk_in;

    indexed_address_alu dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .op_valid_in(op_valid_in), .op_in(op_in),
        .load_valid_in(load_valid_in), .regs_load_in(regs_load_in),
        .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
        .mem_ack_in(mem_ack_in), .mem_data_in(mem_data_in),
        .regs_out(regs_out), .ea_out(ea_out), .busy_out(busy_out),
        .done_out(done_out), .illegal_out(illegal_out));

    far_memory far_mem (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .mem_rd_in(mem_rd_out), .mem_addr_in(mem_addr_out),
        .delay_in(mem_delay), .mem_ack_out(mem_ack_in),
        .mem_data_out(mem_data_in));

    // ********************************
    // Reporting
    // ********************************
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check_regs;
        check("acc_cc", {8'h00, exp_regs.a, exp_regs.b, exp_regs.cc},
              {8'h00, regs_out.a, regs_out.b, regs_out.cc});
        check("x_y", {exp_regs.x, exp_regs.y},
              {regs_out.x, regs_out.y});
        check("u_s", {exp_regs.u, exp_regs.s},
              {regs_out.u, regs_out.s});
        check("pc", {16'h0000, exp_regs.pc}, {16'h0000, regs_out.pc});
    endtask : check_regs

    // ********************************
    // Reference model
    // ********************************
    function automatic logic [15:0] word_at(input logic [15:0] a);
        return {far_mem.byte_at(a), far_mem.byte_at(a + 16'h0001)};
    endfunction : word_at

    task automatic predict(input op_t o);
        logic [15:0] p, ofs, adr, w;
        logic [7:0] acc, m, res;
        logic [8:0] s9;
        logic [16:0] s17;
        logic cin;
        exp_bad = 1'b0;
        case (o.ptr)
            PTR_X: p = exp_regs.x;
            PTR_Y: p = exp_regs.y;
            PTR_U: p = exp_regs.u;
            PTR_S: p = exp_regs.s;
            default: p = exp_regs.pc;
        endcase
        acc = o.acc_second ? exp_regs.b : exp_regs.a;
        m = far_mem.byte_at(o.imm);
        cin = (o.opcode == OP_ADC) ? exp_regs.cc[`CC_C] : 1'b0;
        res = acc;
        case (o.opcode)
            OP_EA: begin
                exp_bad = (o.ptr == PTR_PC && o.mode != EA_CONST) ||
                    (o.mode == EA_ACC && o.ofs == 2'h3) ||
                    (o.mode inside {EA_INC, EA_DEC} && o.indirect &&
                    !o.step_two);
                ofs = (o.ofs == OFS_A) ? {{8{exp_regs.a[7]}}, exp_regs.a} :
                    (o.ofs == OFS_B) ? {{8{exp_regs.b[7]}}, exp_regs.b} :
                    {exp_regs.a, exp_regs.b};
                w = o.step_two ? `STEP_TWO : `STEP_ONE;
                case (o.mode)
                    EA_CONST: adr = p + o.imm;
                    EA_ACC: adr = p + ofs;
                    EA_INC: begin
                        adr = p;
                        p = p + w;
                    end
                    default: begin
                        p = p - w;
                        adr = p;
                    end
                endcase
                if (!exp_bad) begin
                    exp_ea = o.indirect ? word_at(adr) : adr;
                    case (o.ptr)
                        PTR_X: exp_regs.x = p;
                        PTR_Y: exp_regs.y = p;
                        PTR_U: exp_regs.u = p;
                        PTR_S: exp_regs.s = p;
                        default: exp_regs.pc = p;
                    endcase
                end
            end
            OP_BRANCH: begin
                exp_ea = exp_regs.pc + (o.long_rel ? o.imm :
                    {{8{o.imm[7]}}, o.imm[7:0]});
                exp_regs.pc = exp_ea;
            end
            OP_ABX: exp_regs.x = exp_regs.x + {8'h00, exp_regs.b};
            OP_ADC, OP_ADD: begin
                s9 = acc + m + cin;
                res = s9[7:0];
                exp_regs.cc[`CC_H] = (acc[3:0] + m[3:0] + cin) > 5'h0F;
                exp_regs.cc[`CC_V] = (acc[7] == m[7]) && (res[7] != acc[7]);
                exp_regs.cc[`CC_C] = s9[8];
            end
            OP_AND: begin
                res = acc & m;
                exp_regs.cc[`CC_V] = 1'b0;
            end
            OP_ASL: begin
                res = {acc[6:0], 1'b0};
                exp_regs.cc[`CC_C] = acc[7];
                exp_regs.cc[`CC_V] = acc[7] ^ acc[6];
            end
            OP_ADD_DOUBLE_ACC: begin
                w = word_at(o.imm);
                s17 = {exp_regs.a, exp_regs.b} + w;
                exp_regs.cc[`CC_C] = s17[16];
                exp_regs.cc[`CC_V] = (exp_regs.a[7] == w[15]) &&
                    (s17[15] != exp_regs.a[7]);
                exp_regs.cc[`CC_N] = s17[15];
                exp_regs.cc[`CC_Z] = s17[15:0] == 16'h0000;
                {exp_regs.a, exp_regs.b} = s17[15:0];
            end
            OP_ANDCC: exp_regs.cc = exp_regs.cc & o.imm[7:0];
            default: ;
        endcase
        if (o.opcode inside {OP_ADC, OP_ADD, OP_AND, OP_ASL}) begin
            exp_regs.cc[`CC_N] = res[7];
            exp_regs.cc[`CC_Z] = res == 8'h00;
            if (o.acc_second) begin
                exp_regs.b = res;
            end else begin
                exp_regs.a = res;
            end
        end
    endtask : predict

    // ********************************
    // Drivers and sequence
    // ********************************
    task automatic run_op(input op_t o);
        int k;
        logic exp_mem;
        @(posedge mclk_in);
        #1;
        predict(o);
        exp_mem = (o.opcode inside {OP_ADC, OP_ADD, OP_AND, OP_ADD_DOUBLE_ACC}) ||
            (o.opcode == OP_EA && o.indirect && !exp_bad);
        op_in = o;
        op_valid_in = 1'b1;
        @(posedge mclk_in);
        #1;
        op_valid_in = 1'b0;
        check("busy", {31'h0, exp_mem}, {31'h0, busy_out});
        k = 0;
        while (k < 40 && done_out !== 1'b1 && illegal_out !== 1'b1) begin
            @(posedge mclk_in);
            #1;
            k++;
        end
        check("illegal_done", {30'h0, exp_bad, !exp_bad},
              {30'h0, illegal_out, done_out});
        check_regs();
        if (!exp_bad && o.opcode inside {OP_EA, OP_BRANCH}) begin
            check("ea", {16'h0000, exp_ea}, {16'h0000, ea_out});
        end
    endtask : run_op

    task automatic load_regs(input logic [127:0] bits);
        regs_load_in = bits[103:0];
        exp_regs = bits[103:0];
        load_valid_in = 1'b1;
        @(posedge mclk_in);
        #1;
        load_valid_in = 1'b0;
    endtask : load_regs

    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end

    initial begin
        op_t o;
        exp_regs = '0;
        exp_regs.cc = `CC_RESET;
        exp_ea = 16'h0000;
        repeat (8) @(posedge mclk_in);
        #1;
        reset_n_in = 1'b1;
        check_regs();
        check("outputs", 32'h0000_0000, {12'h000, mem_rd_out, busy_out,
              done_out, illegal_out, ea_out});
        check("mem_addr", 32'h0000_0000, {16'h0000, mem_addr_out});
        $display("Reset test done");
        for (int n = 0; n < 600; n++) begin
            if (n % 3 == 0) begin
                load_regs({$random(seed), $random(seed), $random(seed),
                           $random(seed) & ((n % 2) ? 32'hFFFF_FFFF :
                           32'hFF00_FFFF)});
            end
            o = op_t'(31'($random(seed)));
            o.opcode = opcode_t'(4'($unsigned($random(seed)) % 9));
            o.ptr = ptr_sel_t'(3'($unsigned($random(seed)) % 5));
            mem_delay = 2'($random(seed));
            run_op(o);
        end
        $display("Random operation test done");
        give_verdict();
    end
endmodule : testbench
